// ==== inc/pec_pkg.sv ====
// Constants shared by the performance counter block and its helpers.
package pec_pkg;

	localparam int          C0_W          = 16;
	localparam int          C1_W          = 12;
	localparam int          SEL0_W        = 4;
	localparam int          SEL1_W        = 3;
	localparam int          ISSUE_W       = 2;
	localparam int          PC_W          = 62;
	localparam int          EXT_PINS      = 2;

	localparam logic [C0_W-1:0] C0_RESET  = 16'h0000;
	localparam logic [C1_W-1:0] C1_RESET  = 12'h000;
	localparam logic [PC_W-1:0] PC_RESET  = 62'h0;

	// Overflow ranges as powers of two.
	localparam logic [4:0]  C0_SHORT      = 5'h0C;
	localparam logic [4:0]  C0_LONG       = 5'h10;
	localparam logic [4:0]  C1_SHORT      = 5'h08;
	localparam logic [4:0]  C1_LONG       = 5'h0C;

	// Counter 0 select, upper three bits.
	localparam logic [2:0]  C0_ISSUE_HALF = 3'h0;
	localparam logic [2:0]  C0_DRY        = 3'h1;
	localparam logic [2:0]  C0_LOAD       = 3'h2;
	localparam logic [2:0]  C0_FROZEN     = 3'h3;
	localparam logic [2:0]  C0_BRANCH     = 3'h4;
	localparam logic [2:0]  C0_CYCLE_GRP  = 3'h5;
	localparam logic [2:0]  C0_IDLE_HALF  = 3'h6;
	localparam logic [2:0]  C0_EXTERNAL   = 3'h7;
	localparam int          C0_CYCLE_BIT  = 0;

	// Counter 1 select.
	localparam logic [2:0]  C1_DCACHE     = 3'h0;
	localparam logic [2:0]  C1_ICACHE     = 3'h1;
	localparam logic [2:0]  C1_DUAL       = 3'h2;
	localparam logic [2:0]  C1_MISPREDICT = 3'h3;
	localparam logic [2:0]  C1_FP_OP      = 3'h4;
	localparam logic [2:0]  C1_INT_OP     = 3'h5;
	localparam logic [2:0]  C1_STORE      = 3'h6;
	localparam logic [2:0]  C1_EXTERNAL   = 3'h7;

	localparam logic [1:0]  ISSUE_NONE    = 2'h0;
	localparam logic [1:0]  ISSUE_DUAL    = 2'h2;

	localparam int          IRQ_DELAY     = 6;
	localparam int          IRQ_STAGES    = IRQ_DELAY - 1;
	localparam logic [1:0]  MISPRED_BUDGET = 2'h2;
	localparam int          CLR_C0_BIT    = 0;
	localparam int          CLR_C1_BIT    = 1;

	// True when the next event wraps a counter with a 2^bits range.
	function automatic logic pec_at_top(input logic [15:0] cnt, input logic [4:0] bits);
		logic [16:0] mask;
		mask = (17'h00001 << bits) - 17'h00001;
		return (({1'b0, cnt} & mask) == mask);
	endfunction : pec_at_top

endpackage : pec_pkg

// ==== logic/pec_sync.sv ====
// Three-stage pin synchroniser that turns an agreed rising level into one pulse.
module pec_sync
	import pec_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic clk_en,
	input  wire logic pin,
	output logic      pulse
);

	logic sync1_q;
	logic sync2_q;
	logic sync3_q;
	logic level_q;
	logic pulse_q;
	logic agree;

	assign agree = (sync2_q == sync3_q);
	assign pulse = pulse_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end else if (clk_en) begin
			sync1_q <= pin;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// A long high level yields one pulse only, at its start.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= 1'b0;
			pulse_q <= 1'b0;
		end else if (clk_en) begin
			if (agree) begin
				level_q <= sync3_q;
			end
			pulse_q <= agree && sync3_q && !level_q;
		end
	end

endmodule : pec_sync

// ==== logic/pec_delay.sv ====
// Fixed shift line that carries an overflow toward its interrupt request.
module pec_delay
	import pec_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic clk_en,
	input  wire logic din,
	output logic      dout
);

	logic [IRQ_STAGES-1:0] line_q;

	assign dout = line_q[IRQ_STAGES-1];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_q <= '0;
		end else if (clk_en) begin
			line_q <= {line_q[IRQ_STAGES-2:0], din};
		end
	end

endmodule : pec_delay

// ==== logic/pec_counters.sv ====
// Two event counters with delayed overflow requests and a completion hold on counter 1 overflow while it counts icache misses or mispredicts.
module pec_counters
	import pec_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               clk_en,
	input  wire logic [ISSUE_W-1:0] issue_count,
	input  wire logic               pipe_dry,
	input  wire logic               load_instr,
	input  wire logic               pipe_frozen,
	input  wire logic               branch_instr,
	input  wire logic               privileged_firmware,
	input  wire logic               dcache_miss,
	input  wire logic               icache_miss,
	input  wire logic [PC_W-1:0]    icache_miss_pc,
	input  wire logic               branch_mispredict,
	input  wire logic               fp_operate,
	input  wire logic               int_operate,
	input  wire logic               store_instr,
	input  wire logic [EXT_PINS-1:0] external_event_pin,
	input  wire logic [SEL0_W-1:0]  counter0_input_select,
	input  wire logic [SEL1_W-1:0]  counter1_input_select,
	input  wire logic               counter0_range_bit,
	input  wire logic               counter1_range_bit,
	input  wire logic               clear_write,
	input  wire logic [1:0]         clear_data,
	input  wire logic               service_start,
	input  wire logic [1:0]         instr_complete,
	output logic                    counter0_irq,
	output logic                    counter1_irq,
	output logic                    completion_hold,
	output logic [PC_W-1:0]         last_miss_pc
);

	// Counts stay internal; software sees counting only through the requests.
	logic [C0_W-1:0]     count0_q;
	logic [C1_W-1:0]     count1_q;
	logic                issue_half_q;
	logic                idle_half_q;
	logic [1:0]          issue_sum;
	logic                issue_carry;
	logic                idle_carry;
	logic                idle_cycle;
	logic [EXT_PINS-1:0] ext_pulse;
	logic                inc0;
	logic                inc1;
	logic                ovf0;
	logic                ovf1;
	logic                set0;
	logic                set1;
	logic                clr0;
	logic                clr1;
	logic                irq0_q;
	logic                irq1_q;
	logic                window_q;
	logic                strict_q;
	logic [1:0]          used_q;
	logic                icache_sel;
	logic                mispr_sel;
	logic [PC_W-1:0]     miss_pc_q;

	for (genvar i = 0; i < EXT_PINS; i++) begin : g_pin
		pec_sync u_sync (
			.clk    (clk),
			.rst_n  (rst_n),
			.clk_en (clk_en),
			.pin    (external_event_pin[i]),
			.pulse  (ext_pulse[i])
		);
	end

	// Halved counts keep a residue bit so a dual issue adds exactly one.
	assign issue_sum   = {1'b0, issue_half_q} + issue_count;
	assign issue_carry = issue_sum[1];
	assign idle_cycle  = (issue_count == ISSUE_NONE);
	assign idle_carry  = idle_cycle && idle_half_q;

	// Residues run whatever is selected, so reselecting restarts nothing.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			issue_half_q <= 1'b0;
			idle_half_q  <= 1'b0;
		end else if (clk_en) begin
			issue_half_q <= issue_sum[0];
			if (idle_cycle) begin
				idle_half_q <= !idle_half_q;
			end
		end
	end

	// Every strobe counts, so a reissued load after a translation miss counts again.
	always_comb begin
		case (counter0_input_select[SEL0_W-1:1])
			C0_ISSUE_HALF: inc0 = issue_carry;
			C0_DRY:        inc0 = pipe_dry;
			C0_LOAD:       inc0 = load_instr;
			C0_FROZEN:     inc0 = pipe_frozen;
			C0_BRANCH:     inc0 = branch_instr;
			C0_CYCLE_GRP: begin
				if (counter0_input_select[C0_CYCLE_BIT]) begin
					inc0 = 1'b1;
				end else begin
					inc0 = privileged_firmware;
				end
			end
			C0_IDLE_HALF:  inc0 = idle_carry;
			C0_EXTERNAL:   inc0 = ext_pulse[0];
			default:       inc0 = 1'b0;
		endcase
	end

	always_comb begin
		case (counter1_input_select)
			C1_DCACHE:     inc1 = dcache_miss;
			C1_ICACHE:     inc1 = icache_miss;
			C1_DUAL:       inc1 = (issue_count == ISSUE_DUAL);
			C1_MISPREDICT: inc1 = branch_mispredict;
			C1_FP_OP:      inc1 = fp_operate;
			C1_INT_OP:     inc1 = int_operate;
			C1_STORE:      inc1 = store_instr;
			C1_EXTERNAL:   inc1 = ext_pulse[1];
			default:       inc1 = 1'b0;
		endcase
	end

	assign ovf0 = inc0 && pec_at_top(count0_q,
		counter0_range_bit ? C0_SHORT : C0_LONG);
	assign ovf1 = inc1 && pec_at_top({4'h0, count1_q},
		counter1_range_bit ? C1_SHORT : C1_LONG);

	// Only power-up reset clears a counter; wrap returns it to zero.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count0_q <= C0_RESET;
		end else if (clk_en && inc0) begin
			if (ovf0) begin
				count0_q <= C0_RESET;
			end else begin
				count0_q <= count0_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count1_q <= C1_RESET;
		end else if (clk_en && inc1) begin
			if (ovf1) begin
				count1_q <= C1_RESET;
			end else begin
				count1_q <= count1_q + 12'h001;
			end
		end
	end

	pec_delay u_delay0 (
		.clk    (clk),
		.rst_n  (rst_n),
		.clk_en (clk_en),
		.din    (ovf0),
		.dout   (set0)
	);

	pec_delay u_delay1 (
		.clk    (clk),
		.rst_n  (rst_n),
		.clk_en (clk_en),
		.din    (ovf1),
		.dout   (set1)
	);

	assign clr0 = clear_write && !clear_data[CLR_C0_BIT];
	assign clr1 = clear_write && !clear_data[CLR_C1_BIT];

	// A second overflow while still pending merges into the same request.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq0_q <= 1'b0;
		end else if (clk_en) begin
			if (set0) begin
				irq0_q <= 1'b1;
			end else if (clr0) begin
				irq0_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq1_q <= 1'b0;
		end else if (clk_en) begin
			if (set1) begin
				irq1_q <= 1'b1;
			end else if (clr1) begin
				irq1_q <= 1'b0;
			end
		end
	end

	assign counter0_irq = irq0_q;
	assign counter1_irq = irq1_q;

	assign icache_sel = (counter1_input_select == C1_ICACHE);
	assign mispr_sel  = (counter1_input_select == C1_MISPREDICT);

	// The hold relies on the pipeline obeying it in the same cycle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			window_q <= 1'b0;
			strict_q <= 1'b0;
			used_q   <= 2'h0;
		end else if (clk_en) begin
			if (ovf1 && (icache_sel || mispr_sel)) begin
				window_q <= 1'b1;
				strict_q <= icache_sel;
				used_q   <= 2'h0;
			end else if (service_start) begin
				window_q <= 1'b0;
			end else if (window_q && !completion_hold) begin
				used_q   <= used_q + instr_complete;
			end
		end
	end

	always_comb begin
		if (ovf1 && icache_sel) begin
			completion_hold = 1'b1;
		end else if (window_q) begin
			completion_hold = strict_q || (used_q >= MISPRED_BUDGET);
		end else begin
			completion_hold = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			miss_pc_q <= PC_RESET;
		end else if (clk_en && icache_miss) begin
			miss_pc_q <= icache_miss_pc;
		end
	end

	assign last_miss_pc = miss_pc_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_ovf0;
		ovf0 && clk_en;
	endsequence

	sequence s_ovf1;
		ovf1 && clk_en;
	endsequence

	// The request flop sets on the fifth running edge after the overflow edge.
	sequence s_run5;
		clk_en [*5];
	endsequence

	a_irq0_delay: assert property (s_ovf0 ##1 s_run5 |=> counter0_irq)
		else $error("counter 0 request late");

	a_irq1_delay: assert property (s_ovf1 ##1 s_run5 |=> counter1_irq)
		else $error("counter 1 request late");

	a_irq0_early: assert property (ovf0 && clk_en && !counter0_irq
		|=> (!counter0_irq) [*5])
		else $error("counter 0 request early");

	a_irq0_hold: assert property (counter0_irq && !clr0 |=> counter0_irq)
		else $error("counter 0 request dropped");

	a_irq1_clear: assert property (clk_en && clr1 && !set1 |=> !counter1_irq)
		else $error("counter 1 request not cleared");

	a_c0_wrap_zero: assert property (s_ovf0 |=> count0_q == C0_RESET)
		else $error("counter 0 did not wrap");

	a_c0_step_one: assert property (clk_en && inc0 && !ovf0
		|=> count0_q == $past(count0_q) + 16'h0001)
		else $error("counter 0 step wrong");

	a_c1_still: assert property (!(clk_en && inc1) |=> $stable(count1_q))
		else $error("counter 1 changed without event");

	a_c0_range: assert property (inc0 && counter0_range_bit
		|-> ovf0 == (count0_q[11:0] == 12'hFFF))
		else $error("counter 0 short range wrong");

	a_c1_range: assert property (inc1 && !counter1_range_bit
		|-> ovf1 == (count1_q == 12'hFFF))
		else $error("counter 1 long range wrong");

	a_hold_strict: assert property (clk_en && ovf1 && icache_sel
		|-> completion_hold ##1 completion_hold)
		else $error("completion not held");

	a_budget_free: assert property (window_q && !strict_q && used_q < MISPRED_BUDGET
		&& !(ovf1 && icache_sel) |-> !completion_hold)
		else $error("completion held too soon");

	a_miss_pc: assert property (clk_en && icache_miss
		|=> last_miss_pc == $past(icache_miss_pc))
		else $error("miss address not saved");

	a_ext_once: assert property (ext_pulse[0] && clk_en |=> !ext_pulse[0])
		else $error("external event pulse too long");

endmodule : pec_counters

// ==== verification/pec_pipe_model.sv ====
// Pipeline stand-in that retires instructions and starts interrupt service on request.
module pec_pipe_model
	import pec_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic completion_hold,
	input  wire logic serve_req,
	output logic [1:0] instr_complete,
	output logic       service_start
);
	timeunit 1ns;
	timeprecision 1ns;

	// One instruction retires in every cycle the hold is low, so the window is always pressed.
	assign instr_complete = completion_hold ? 2'h0 : 2'h1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			service_start <= 1'b0;
		end else begin
			service_start <= serve_req;
		end
	end
endmodule : pec_pipe_model

// ==== verification/cpu_event_performance_counters_bench.sv ====
// Self-checking bench for the two event counters.
module cpu_event_performance_counters_bench
	import pec_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;

	logic                clk;
	logic                rst_n;
	logic                clk_en;
	logic [10:0]         ev;
	logic [ISSUE_W-1:0]  issue_count;
	logic [PC_W-1:0]     icache_miss_pc;
	logic [EXT_PINS-1:0] external_event_pin;
	logic [SEL0_W-1:0]   counter0_input_select;
	logic [SEL1_W-1:0]   counter1_input_select;
	logic                counter0_range_bit;
	logic                counter1_range_bit;
	logic                clear_write;
	logic [1:0]          clear_data;
	logic                serve_req;
	logic                service_start;
	logic [1:0]          instr_complete;
	logic                counter0_irq;
	logic                counter1_irq;
	logic                completion_hold;
	logic [PC_W-1:0]     last_miss_pc;
	int                  n_mismatch;
	int                  samples_checked;
	int                  k;
	int                  ncomp;

	pec_counters u_dut (
		.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .issue_count(issue_count),
		.pipe_dry(ev[0]), .load_instr(ev[1]), .pipe_frozen(ev[2]), .branch_instr(ev[3]),
		.privileged_firmware(ev[4]), .dcache_miss(ev[5]), .icache_miss(ev[6]),
		.icache_miss_pc(icache_miss_pc), .branch_mispredict(ev[7]), .fp_operate(ev[8]),
		.int_operate(ev[9]), .store_instr(ev[10]), .external_event_pin(external_event_pin),
		.counter0_input_select(counter0_input_select),
		.counter1_input_select(counter1_input_select),
		.counter0_range_bit(counter0_range_bit), .counter1_range_bit(counter1_range_bit),
		.clear_write(clear_write), .clear_data(clear_data), .service_start(service_start),
		.instr_complete(instr_complete), .counter0_irq(counter0_irq),
		.counter1_irq(counter1_irq), .completion_hold(completion_hold),
		.last_miss_pc(last_miss_pc)
	);

	pec_pipe_model u_pipe (
		.clk(clk), .rst_n(rst_n), .completion_hold(completion_hold), .serve_req(serve_req),
		.instr_complete(instr_complete), .service_start(service_start)
	);

	always #20 clk = ~clk;

	task automatic chk_bit(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask : chk_bit

	task automatic chk_int(input string what, input int exp, input int got);
		samples_checked++;
		if (got != exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %0d, seen %0d", what, exp, got);
		end
	endtask : chk_int

	task automatic chk_pc(input string what, input logic [PC_W-1:0] exp, input logic [PC_W-1:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk_pc

	task automatic end_sim;
		$display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim

	function automatic logic irq_of(input bit c1);
		return c1 ? counter1_irq : counter0_irq;
	endfunction : irq_of

	// Feeds n units of one event kind; k counts cycles from the last event cycle to the request.
	// Index 11 is a dual issue, 12 an idle cycle, 13 one external pin pulse, 14 a single issue.
	task automatic run(input bit c1, input logic [3:0] code, input int idx, input int n);
		int i;
		int j;
		for (i = 0; i < n; i++) begin
			@(posedge clk);
			counter0_input_select <= c1 ? 4'h8 : code;
			counter1_input_select <= c1 ? code[2:0] : 3'h6;
			icache_miss_pc <= PC_W'(i + 1);
			ev <= (idx < 11) ? (11'h001 << idx) : 11'h000;
			issue_count <= (idx == 11) ? 2'h2 : ((idx == 14) ? 2'h1 : 2'h0);
			if (idx == 13) begin
				external_event_pin <= c1 ? 2'h2 : 2'h1;
				repeat (3) @(posedge clk);
				external_event_pin <= 2'h0;
				repeat (2) @(posedge clk);
			end
		end
		@(posedge clk);
		ev <= 11'h000;
		issue_count <= 2'h0;
		k = 99;
		ncomp = 0;
		for (j = 0; j <= 10; j++) begin
			#1;
			if (k == 99 && irq_of(c1) === 1'b1) k = j + 1;
			if (instr_complete !== 2'h0) ncomp++;
			@(posedge clk);
		end
	endtask : run

	task automatic clr(input bit c1);
		@(posedge clk);
		clear_write <= 1'b1;
		clear_data <= c1 ? 2'b01 : 2'b10;
		@(posedge clk);
		clear_write <= 1'b0;
		clear_data <= 2'b11;
		#1;
		chk_bit("irq cleared", 1'b0, irq_of(c1));
		chk_bit("other irq", 1'b0, irq_of(!c1));
	endtask : clr

	// Mode 0 wants the request exactly six cycles late, 1 within the bound, 2 not at all.
	task automatic row(input bit c1, input logic [3:0] code, input int idx, input int n,
		input int mode);
		run(c1, code, idx, n);
		if (mode == 0) chk_int("irq delay", IRQ_DELAY, k);
		else if (mode == 1) chk_bit("irq raised", 1'b1, k <= 10);
		else chk_int("irq absent", 99, k);
		if (mode != 2) clr(c1);
	endtask : row

	task automatic serve;
		int i;
		@(posedge clk);
		serve_req <= 1'b1;
		@(posedge clk);
		serve_req <= 1'b0;
		#1;
		for (i = 0; i < 8 && completion_hold !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
		chk_bit("hold released", 1'b0, completion_hold);
		if (completion_hold !== 1'b0) end_sim();
	endtask : serve

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		ev = 11'h000;
		issue_count = 2'h0;
		icache_miss_pc = '0;
		external_event_pin = 2'h0;
		counter0_input_select = 4'h8;
		counter1_input_select = 3'h6;
		counter0_range_bit = 1'b1;
		counter1_range_bit = 1'b1;
		clear_write = 1'b0;
		clear_data = 2'b11;
		serve_req = 1'b0;
		n_mismatch = 0;
		samples_checked = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk_bit("c0 irq", 1'b0, counter0_irq);
		chk_bit("c1 irq", 1'b0, counter1_irq);
		chk_bit("hold", 1'b0, completion_hold);
		chk_pc("miss pc", '0, last_miss_pc);
		row(1, 4'h6, 10, 256, 0);
		run(1, 4'h6, 10, 512);
		chk_bit("irq held", 1'b1, counter1_irq);
		clr(1);
		row(1, 4'h6, 10, 256, 0);
		run(1, 4'h0, 5, 128);
		chk_int("irq absent", 99, k);
		row(1, 4'h6, 10, 128, 0);
		row(1, 4'h0, 5, 256, 0);
		row(1, 4'h1, 6, 256, 0);
		chk_int("completions", 0, ncomp);
		chk_bit("hold", 1'b1, completion_hold);
		chk_pc("miss pc", PC_W'(256), last_miss_pc);
		serve();
		row(1, 4'h2, 11, 256, 0);
		row(1, 4'h3, 7, 256, 0);
		chk_bit("completions", 1'b1, ncomp <= 2);
		chk_bit("hold", 1'b1, completion_hold);
		serve();
		row(1, 4'h4, 8, 256, 0);
		row(1, 4'h5, 9, 256, 0);
		run(1, 4'h6, 10, 255);
		chk_int("irq absent", 99, k);
		// Strobes seen while the clock enable is low must leave the count untouched.
		@(posedge clk);
		clk_en <= 1'b0;
		ev <= 11'h400;
		repeat (7) @(posedge clk);
		clk_en <= 1'b1;
		ev <= 11'h000;
		#1;
		chk_bit("frozen irq", 1'b0, counter1_irq);
		row(1, 4'h6, 10, 1, 0);
		run(1, 4'h7, 13, 255);
		chk_int("irq absent", 99, k);
		row(1, 4'h7, 13, 1, 1);
		@(posedge clk);
		counter1_range_bit <= 1'b0;
		row(1, 4'h6, 10, 4096, 0);
		@(posedge clk);
		counter1_range_bit <= 1'b1;
		row(0, 4'h1, 11, 4096, 0);
		row(0, 4'h0, 14, 8192, 0);
		row(0, 4'h2, 0, 4096, 0);
		row(0, 4'h5, 1, 4096, 0);
		row(0, 4'h6, 2, 4096, 0);
		row(0, 4'h9, 3, 4096, 0);
		row(0, 4'hA, 4, 4096, 0);
		run(0, 4'hE, 13, 4095);
		chk_int("irq absent", 99, k);
		row(0, 4'hE, 13, 1, 1);
		row(0, 4'hD, 12, 8192, 1);
		row(0, 4'hB, 12, 4096, 1);
		@(posedge clk);
		counter0_range_bit <= 1'b0;
		row(0, 4'hB, 12, 4096, 2);
		end_sim();
	end
endmodule : cpu_event_performance_counters_bench
